// ===== hw/bt_defines.svh
// Purpose: shared constants of the pipelined bus transaction tracker
// Assumes: one bus clock, synchronous active-high reset
// Notes:   definitions only
`ifndef BT_DEFINES_SVH
`define BT_DEFINES_SVH

// ==========================================================
// queue sizing
`define BT_IOQ_DEPTH     4'h8
`define BT_SHALLOW_DEPTH 4'h1
`define BT_PTR_W         3
`define BT_OWN_LIMIT     4'h4

// ==========================================================
// phase timing, in clocks after the address clock, and data chunk counts
`define BT_ERR_AGE       3'h3
`define BT_SNOOP_AGE     3'h4
`define BT_AGE_MAX       3'h4
`define BT_LINE_CHUNKS   3'h4
`define BT_PART_CHUNKS   3'h1

// ==========================================================
// second request clock layout on the request pins
`define BT_B_BE_LO       3
`define BT_B_BE_HI       10
`define BT_B_DID_LO      11
`define BT_B_DID_HI      18
`define BT_B_PAR         19

`endif

// ===== hw/bus_requester_end.sv
// Purpose: requesting processor end with its own in-order queue
// Assumes: single clk, sys_rst synchronous active high
// Notes:   issue every second clock at best; one requester on the bus
`timescale 1ns/10ps
`include "bt_defines.svh"

module bus_requester_end #(
  parameter bit DEEP_PIPE = 1'b1,
  parameter int OWN_LIMIT = 4
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // bus side
  txn_bus_if.requester     bus,
  // user request
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic        req_write,
  input  wire logic        req_line,
  input  wire logic [35:3] req_addr,
  input  wire logic [7:0]  req_be,
  input  wire logic        req_bad_parity,
  // write data source
  output logic             wr_pull,
  input  wire logic [63:0] wr_data,
  // completion
  output logic             done_valid,
  output txn_pkg::resp_t   done_resp,
  output logic             rd_valid,
  output logic [63:0]      rd_data,
  output logic [3:0]       outstanding
);

  // ==========================================================
  // declarations
  localparam logic [3:0] MAX_OUT =
    DEEP_PIPE ? `BT_IOQ_DEPTH : `BT_SHALLOW_DEPTH;
  localparam logic [3:0] OWN_MAX = 4'(OWN_LIMIT);

  txn_pkg::ioq_entry_t        in_order_queue [8];
  txn_pkg::ioq_entry_t        head;
  logic [7:0]                 valid_vec;
  logic [7:0]                 mine_vec;
  logic [`BT_PTR_W-1:0]       wr_ptr;
  logic [`BT_PTR_W-1:0]       snp_ptr;
  logic [`BT_PTR_W-1:0]       head_ptr;
  logic [3:0]                 own_count;
  logic                       b_phase;
  logic [7:0]                 b_be;
  logic [7:0]                 b_did;
  logic                       b_par;
  logic                       issue;
  logic [2:0]                 wr_left;

  assign head        = in_order_queue[head_ptr];
  assign outstanding = txn_pkg::count_ones(valid_vec);
  assign own_count   = txn_pkg::count_ones(valid_vec & mine_vec);

  // ==========================================================
  // arbitration and issue
  // grant stays up while we keep asking, so back-to-back issue skips
  // a fresh arbitration
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bus.bus_req <= 1'b0;
    end else begin
      bus.bus_req <= req_valid;
    end
  end

  // strobe high and no second clock pending: the pins are free
  assign issue = req_valid && bus.bus_grant && !b_phase
                 && bus.address_strobe_n
                 && (outstanding < MAX_OUT)
                 && (own_count < OWN_MAX);
  assign req_ready = issue;

  // ==========================================================
  // two-clock request phase
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bus.address_strobe_n <= 1'b1;
      bus.req_pins         <= 33'h000000000;
      bus.req_type         <= 2'h0;
      b_phase              <= 1'b0;
      b_be                 <= 8'h00;
      b_did                <= 8'h00;
      b_par                <= 1'b0;
    end else begin
      bus.address_strobe_n <= !issue;
      b_phase              <= issue;
      if (issue) begin
        bus.req_pins <= req_addr;
        bus.req_type <= {req_write, req_line};
        b_be         <= req_be;
        b_did        <= {5'h00, wr_ptr};
        b_par        <= (^req_addr) ^ req_bad_parity;
      end else if (b_phase) begin
        bus.req_pins <= {16'h0000, b_par, b_did, b_be};
      end
    end
  end

  // ==========================================================
  // in-order queue
  for (genvar i = 0; i < 8; i++) begin : g_ioq
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        in_order_queue[i] <= '0;
      end else if (!bus.address_strobe_n
                   && wr_ptr == `BT_PTR_W'(i)) begin
        in_order_queue[i] <= '{valid: 1'b1, age: 3'h1,
                               write: bus.req_type[1],
                               line: bus.req_type[0],
                               perr: 1'b0, snooped: 1'b0,
                               hitm: 1'b0, defer: 1'b0,
                               mine: 1'b1};
      end else if (in_order_queue[i].valid) begin
        if (in_order_queue[i].age != `BT_AGE_MAX) begin
          in_order_queue[i].age <= in_order_queue[i].age + 3'h1;
        end
        if (in_order_queue[i].age == `BT_ERR_AGE
            && !bus.error_n) begin
          in_order_queue[i].valid <= 1'b0;
        end else if (bus.resp_valid
                     && head_ptr == `BT_PTR_W'(i)) begin
          in_order_queue[i].valid <= 1'b0;
        end
        if (bus.snoop_valid && snp_ptr == `BT_PTR_W'(i)) begin
          in_order_queue[i].snooped <= 1'b1;
          in_order_queue[i].hitm    <= bus.snoop_hitm;
          in_order_queue[i].defer   <= bus.snoop_defer;
        end
      end
    end
    assign valid_vec[i] = in_order_queue[i].valid;
    assign mine_vec[i]  = in_order_queue[i].mine;
  end

  // snoop and head pointers skip entries that an error already retired
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_ptr   <= '0;
      snp_ptr  <= '0;
      head_ptr <= '0;
    end else begin
      if (!bus.address_strobe_n) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (bus.snoop_valid || (!in_order_queue[snp_ptr].valid
                              && snp_ptr != wr_ptr)) begin
        snp_ptr <= snp_ptr + 1'b1;
      end
      if (bus.resp_valid || (!head.valid && head_ptr != wr_ptr)) begin
        head_ptr <= head_ptr + 1'b1;
      end
    end
  end

  // ==========================================================
  // write data, launched by target ready
  assign wr_pull = !bus.target_ready_n || (wr_left != 3'h0);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bus.wdata_valid <= 1'b0;
      bus.wdata       <= 64'h0000000000000000;
      wr_left         <= 3'h0;
    end else begin
      bus.wdata_valid <= wr_pull;
      if (wr_pull) begin
        bus.wdata <= wr_data;
      end
      if (!bus.target_ready_n) begin
        wr_left <= txn_pkg::chunk_count(head.line) - 3'h1;
      end else if (wr_left != 3'h0) begin
        wr_left <= wr_left - 3'h1;
      end
    end
  end

  // ==========================================================
  // completion toward the user
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      done_valid <= 1'b0;
      done_resp  <= txn_pkg::RESP_NORMAL_DATA;
      rd_valid   <= 1'b0;
      rd_data    <= 64'h0000000000000000;
    end else begin
      done_valid <= bus.resp_valid;
      if (bus.resp_valid) begin
        done_resp <= bus.resp_code;
      end
      rd_valid <= bus.rdata_valid;
      if (bus.rdata_valid) begin
        rd_data <= bus.rdata;
      end
    end
  end

endmodule

// ===== hw/bus_responder_end.sv
// Purpose: responding agent end: arbiter, error, snoop, response, data
// Assumes: single clk, sys_rst synchronous active high
// Notes:   answers every transaction without a parity error; one response in flight at a time
`timescale 1ns/10ps
`include "bt_defines.svh"

module bus_responder_end (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // bus side
  txn_bus_if.responder     bus,
  // user controls
  input  wire logic        hold_off,
  input  wire logic        snoop_hit_in,
  input  wire logic        snoop_hitm_in,
  input  wire logic        defer_in,
  input  wire logic        retry_in,
  input  wire logic        fail_in,
  // read data source
  output logic             rd_pull,
  input  wire logic [63:0] rd_src,
  // write data sink
  output logic             wr_valid,
  output logic [63:0]      wr_data,
  output logic [3:0]       outstanding
);

  // ==========================================================
  // declarations
  txn_pkg::ioq_entry_t        in_order_queue [8];
  txn_pkg::ioq_entry_t        head;
  txn_pkg::ioq_entry_t        snp;
  txn_pkg::resp_state_t       state;
  txn_pkg::resp_t             pick;
  txn_pkg::resp_t             held_code;
  logic [7:0]                 valid_vec;
  logic [7:0]                 perr_vec;
  logic [`BT_PTR_W-1:0]       wr_ptr;
  logic [`BT_PTR_W-1:0]       snp_ptr;
  logic [`BT_PTR_W-1:0]       head_ptr;
  logic                       a_par;
  logic                       snoop_go;
  logic                       head_ok;
  logic                       go_read;
  logic                       go_write;
  logic [2:0]                 cnt;

  assign head        = in_order_queue[head_ptr];
  assign snp         = in_order_queue[snp_ptr];
  assign outstanding = txn_pkg::count_ones(valid_vec);

  // ==========================================================
  // arbitration: grant withheld while buffers are short
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bus.bus_grant <= 1'b0;
    end else begin
      bus.bus_grant <= bus.bus_req && !hold_off;
    end
  end

  // ==========================================================
  // in-order queue, same view as every other agent
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      a_par <= 1'b0;
    end else if (!bus.address_strobe_n) begin
      a_par <= ^bus.req_pins;
    end
  end

  for (genvar i = 0; i < 8; i++) begin : g_ioq
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        in_order_queue[i] <= '0;
      end else if (!bus.address_strobe_n
                   && wr_ptr == `BT_PTR_W'(i)) begin
        in_order_queue[i] <= '{valid: 1'b1, age: 3'h1,
                               write: bus.req_type[1],
                               line: bus.req_type[0],
                               perr: 1'b0, snooped: 1'b0,
                               hitm: 1'b0, defer: 1'b0,
                               mine: 1'b1};
      end else if (in_order_queue[i].valid) begin
        if (in_order_queue[i].age != `BT_AGE_MAX) begin
          in_order_queue[i].age <= in_order_queue[i].age + 3'h1;
        end
        if (in_order_queue[i].age == 3'h1) begin
          in_order_queue[i].perr <= a_par != bus.req_pins[`BT_B_PAR];
        end
        if (in_order_queue[i].age == `BT_ERR_AGE
            && !bus.error_n) begin
          in_order_queue[i].valid <= 1'b0;
        end else if (bus.resp_valid
                     && head_ptr == `BT_PTR_W'(i)) begin
          in_order_queue[i].valid <= 1'b0;
        end
        if (bus.snoop_valid && snp_ptr == `BT_PTR_W'(i)) begin
          in_order_queue[i].snooped <= 1'b1;
          in_order_queue[i].hitm    <= bus.snoop_hitm;
          in_order_queue[i].defer   <= bus.snoop_defer;
        end
      end
    end
    assign valid_vec[i] = in_order_queue[i].valid;
    assign perr_vec[i]  = in_order_queue[i].valid
                          && in_order_queue[i].perr
                          && in_order_queue[i].age == (`BT_ERR_AGE - 3'h1);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_ptr   <= '0;
      snp_ptr  <= '0;
      head_ptr <= '0;
    end else begin
      if (!bus.address_strobe_n) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (bus.snoop_valid || (!snp.valid && snp_ptr != wr_ptr)) begin
        snp_ptr <= snp_ptr + 1'b1;
      end
      if (bus.resp_valid || (!head.valid && head_ptr != wr_ptr)) begin
        head_ptr <= head_ptr + 1'b1;
      end
    end
  end

  // ==========================================================
  // error and snoop phases
  // snoop held off one clock after each result so a pointer that has
  // not moved yet is never snooped twice
  assign snoop_go = snp.valid && !snp.perr && !bus.snoop_valid
                    && snp.age >= (`BT_SNOOP_AGE - 3'h1);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bus.error_n     <= 1'b1;
      bus.snoop_valid <= 1'b0;
      bus.snoop_hit   <= 1'b0;
      bus.snoop_hitm  <= 1'b0;
      bus.snoop_defer <= 1'b0;
    end else begin
      bus.error_n     <= !(|perr_vec);
      bus.snoop_valid <= snoop_go;
      bus.snoop_hit   <= snoop_go && snoop_hit_in;
      bus.snoop_hitm  <= snoop_go && snoop_hitm_in;
      bus.snoop_defer <= snoop_go && defer_in;
    end
  end

  // ==========================================================
  // response and data phases
  always_comb begin
    if (fail_in) begin
      pick = txn_pkg::RESP_HARD_FAIL;
    end else if (retry_in) begin
      pick = txn_pkg::RESP_RETRY;
    end else if (head.defer) begin
      pick = txn_pkg::RESP_DEFERRED;
    end else if (head.hitm) begin
      pick = txn_pkg::RESP_IMPLICIT_WB;
    end else if (head.write) begin
      pick = txn_pkg::RESP_NO_DATA;
    end else begin
      pick = txn_pkg::RESP_NORMAL_DATA;
    end
  end

  assign head_ok  = state == txn_pkg::RS_IDLE && head.valid
                    && head.snooped;
  assign go_write = head_ok && head.write
                    && (pick == txn_pkg::RESP_NO_DATA
                        || pick == txn_pkg::RESP_IMPLICIT_WB);
  assign go_read  = head_ok && !head.write
                    && (pick == txn_pkg::RESP_NORMAL_DATA
                        || pick == txn_pkg::RESP_IMPLICIT_WB);
  assign rd_pull  = go_read || state == txn_pkg::RS_READ_DATA;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state              <= txn_pkg::RS_IDLE;
      bus.resp_valid     <= 1'b0;
      bus.resp_code      <= txn_pkg::RESP_NORMAL_DATA;
      bus.target_ready_n <= 1'b1;
      held_code          <= txn_pkg::RESP_NORMAL_DATA;
      cnt                <= 3'h0;
    end else begin
      bus.resp_valid     <= 1'b0;
      bus.target_ready_n <= 1'b1;
      case (state)
        txn_pkg::RS_IDLE: begin
          if (go_write) begin
            bus.target_ready_n <= 1'b0;
            held_code          <= pick;
            cnt                <= txn_pkg::chunk_count(head.line);
            state              <= txn_pkg::RS_WRITE_DATA;
          end else if (head_ok) begin
            bus.resp_valid <= 1'b1;
            bus.resp_code  <= pick;
            cnt <= txn_pkg::chunk_count(head.line) - 3'h1;
            if (go_read && head.line) begin
              state <= txn_pkg::RS_READ_DATA;
            end else begin
              state <= txn_pkg::RS_GAP;
            end
          end
        end
        txn_pkg::RS_READ_DATA: begin
          cnt <= cnt - 3'h1;
          if (cnt == 3'h1) begin
            state <= txn_pkg::RS_IDLE;
          end
        end
        txn_pkg::RS_WRITE_DATA: begin
          if (bus.wdata_valid) begin
            cnt <= cnt - 3'h1;
            if (cnt == 3'h1) begin
              bus.resp_valid <= 1'b1;
              bus.resp_code  <= held_code;
              state          <= txn_pkg::RS_GAP;
            end
          end
        end
        txn_pkg::RS_GAP: begin
          state <= txn_pkg::RS_IDLE;
        end
        default: begin
          state <= txn_pkg::RS_IDLE;
        end
      endcase
    end
  end

  // data registers: read burst out, write chunks to the user
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bus.rdata_valid <= 1'b0;
      bus.rdata       <= 64'h0000000000000000;
      wr_valid        <= 1'b0;
      wr_data         <= 64'h0000000000000000;
    end else begin
      bus.rdata_valid <= rd_pull;
      if (rd_pull) begin
        bus.rdata <= rd_src;
      end
      wr_valid <= bus.wdata_valid;
      if (bus.wdata_valid) begin
        wr_data <= bus.wdata;
      end
    end
  end

endmodule

// ===== hw/txn_bus_if.sv
// Purpose: wires between the requesting and the responding bus end
// Assumes: both ends clocked by the same clk
// Notes:   all signals point one way, no shared drivers
`timescale 1ns/10ps

interface txn_bus_if;
  // ==========================================================
  // requester driven
  logic                 bus_req;
  logic                 address_strobe_n;
  logic [35:3]          req_pins;
  logic [1:0]           req_type;
  logic                 wdata_valid;
  logic [63:0]          wdata;
  // ==========================================================
  // responder driven
  logic                 bus_grant;
  logic                 error_n;
  logic                 snoop_valid;
  logic                 snoop_hit;
  logic                 snoop_hitm;
  logic                 snoop_defer;
  logic                 resp_valid;
  txn_pkg::resp_t       resp_code;
  logic                 target_ready_n;
  logic                 rdata_valid;
  logic [63:0]          rdata;

  modport requester (
    output bus_req, address_strobe_n, req_pins, req_type, wdata_valid, wdata,
    input  bus_grant, error_n, snoop_valid, snoop_hit, snoop_hitm,
    input  snoop_defer, resp_valid, resp_code, target_ready_n,
    input  rdata_valid, rdata
  );
  modport responder (
    input  bus_req, address_strobe_n, req_pins, req_type, wdata_valid, wdata,
    output bus_grant, error_n, snoop_valid, snoop_hit, snoop_hitm,
    output snoop_defer, resp_valid, resp_code, target_ready_n,
    output rdata_valid, rdata
  );
endinterface

// ===== hw/txn_pkg.sv
// Purpose: types and helpers shared by both bus ends
// Assumes: bt_defines.svh on the include path
// Notes:   no state lives here
`include "bt_defines.svh"

package txn_pkg;

  // ==========================================================
  // response outcomes
  typedef enum logic [2:0] {
    RESP_NORMAL_DATA,
    RESP_IMPLICIT_WB,
    RESP_NO_DATA,
    RESP_HARD_FAIL,
    RESP_DEFERRED,
    RESP_RETRY
  } resp_t;

  typedef enum logic [1:0] {
    RS_IDLE,
    RS_READ_DATA,
    RS_WRITE_DATA,
    RS_GAP
  } resp_state_t;

  // ==========================================================
  // one in-order queue entry
  typedef struct packed {
    logic       valid;
    logic [2:0] age;
    logic       write;
    logic       line;
    logic       perr;
    logic       snooped;
    logic       hitm;
    logic       defer;
    logic       mine;
  } ioq_entry_t;

  function automatic logic [3:0] count_ones(input logic [7:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int k = 0; k < 8; k++) begin
      n = n + {3'h0, v[k]};
    end
    return n;
  endfunction

  function automatic logic [2:0] chunk_count(input logic line);
    return line ? `BT_LINE_CHUNKS : `BT_PART_CHUNKS;
  endfunction

endpackage

// ===== test/pipelined_bus_transaction_tracker_tb.sv
// Purpose: joins both ends and runs the scenarios
// Assumes: 100 MHz clk, reset held 6 clocks
// Notes:   inputs move 1 ns after the rising edge
`timescale 1ns/10ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin miscompares++; \
  $display("[ERR] %0t got %0h exp %0h", $time, a, b); end end

module pipelined_bus_transaction_tracker_tb;
  logic clk, sys_rst, req_valid, req_ready, req_write, req_line, bad_par;
  logic hold_off, hit, hitm, defer, retry, fail, wr_pull, rd_pull;
  logic done_valid, rd_valid, sink_valid;
  logic [35:3] req_addr;
  logic [7:0] req_be;
  logic [63:0] src_wdata, rd_src, rd_data, sink_data;
  logic [3:0] req_out, rsp_out, peak;
  txn_pkg::resp_t done_resp;
  int miscompares = 0, n_checks = 0, n_done, n_wp, n_rp, n_hit;
  txn_bus_if bus ();
  bus_requester_end #(.DEEP_PIPE(1'b1), .OWN_LIMIT(4))
    bus_requester_end_inst (.clk(clk), .sys_rst(sys_rst), .bus(bus),
    .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
    .req_line(req_line), .req_addr(req_addr), .req_be(req_be),
    .req_bad_parity(bad_par), .wr_pull(wr_pull), .wr_data(src_wdata),
    .done_valid(done_valid), .done_resp(done_resp), .rd_valid(rd_valid),
    .rd_data(rd_data), .outstanding(req_out));
  bus_responder_end bus_responder_end_inst (.clk(clk), .sys_rst(sys_rst),
    .bus(bus), .hold_off(hold_off), .snoop_hit_in(hit),
    .snoop_hitm_in(hitm), .defer_in(defer), .retry_in(retry),
    .fail_in(fail), .rd_pull(rd_pull), .rd_src(rd_src),
    .wr_valid(sink_valid), .wr_data(sink_data), .outstanding(rsp_out));
  txn_bus_chk txn_bus_chk_inst (.clk(clk), .sys_rst(sys_rst),
    .address_strobe_n(bus.address_strobe_n), .bus_grant(bus.bus_grant),
    .error_n(bus.error_n), .snoop_valid(bus.snoop_valid),
    .resp_valid(bus.resp_valid), .resp_code(bus.resp_code),
    .target_ready_n(bus.target_ready_n), .wdata_valid(bus.wdata_valid),
    .rdata_valid(bus.rdata_valid));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // both queues must agree every clock
  always @(posedge clk) begin
    if (!sys_rst) `CHK(req_out, rsp_out)
    if (done_valid === 1'b1) n_done++;
    if (wr_pull === 1'b1) n_wp++;
    if (rd_pull === 1'b1) n_rp++;
    if (bus.snoop_hit === 1'b1) n_hit++;
    if (req_out > peak) peak = req_out;
  end
  task automatic issue(input logic w, input logic l, input logic b);
    int k;
    {req_write, req_line, bad_par, req_valid} = {w, l, b, 1'b1};
    for (k = 0; k < 30 && req_ready !== 1'b1; k++) @(posedge clk) #1;
    `CHK(req_ready, 1'b1)
    @(posedge clk) #1;
    req_valid = 1'b0;
  endtask
  // n counts clocks from the taking edge
  task automatic wait_done(input txn_pkg::resp_t code, output int n);
    for (n = 1; n < 30 && done_valid !== 1'b1; n++) @(posedge clk) #1;
    `CHK(done_valid, 1'b1)
    `CHK(done_resp, code)
  endtask
  task automatic t_read;
    int n;
    issue(1'b0, 1'b0, 1'b0);
    wait_done(txn_pkg::RESP_NORMAL_DATA, n);
    `CHK(n, 8)
    `CHK(rd_valid, 1'b1)
    `CHK(rd_data, rd_src)
  endtask
  task automatic t_write;
    int n;
    issue(1'b1, 1'b0, 1'b0);
    for (n = 0; n < 20 && sink_valid !== 1'b1; n++) @(posedge clk) #1;
    `CHK(sink_data, src_wdata)
    wait_done(txn_pkg::RESP_NO_DATA, n);
  endtask
  task automatic t_error;
    int seen;
    seen = 0;
    issue(1'b0, 1'b0, 1'b1);
    repeat (2) @(posedge clk) #1;
    `CHK(req_out, 4'h1)
    repeat (2) @(posedge clk) #1;
    `CHK(req_out, 4'h0)
    repeat (12) @(posedge clk) #1 seen |= done_valid;
    `CHK(seen, 0)
  endtask
  task automatic t_codes;
    txn_pkg::resp_t exp [4];
    int n;
    exp = '{txn_pkg::RESP_HARD_FAIL, txn_pkg::RESP_RETRY,
            txn_pkg::RESP_DEFERRED, txn_pkg::RESP_IMPLICIT_WB};
    n_hit = 0;
    for (int i = 0; i < 4; i++) begin
      {fail, retry, defer, hitm} = 4'h8 >> i;
      hit = (i == 3);
      issue(1'b0, 1'b0, 1'b0);
      wait_done(exp[i], n);
    end
    {fail, retry, defer, hitm, hit} = 5'h00;
    `CHK(n_hit, 1)
  endtask
  task automatic t_stall;
    int n;
    n = 0;
    {hold_off, req_valid} = 2'h3;
    repeat (6) @(posedge clk) #1 n |= req_ready;
    `CHK(n, 0)
    hold_off = 1'b0;
    t_read;
    n_rp = 0;
    issue(1'b0, 1'b1, 1'b0);
    wait_done(txn_pkg::RESP_NORMAL_DATA, n);
    repeat (4) @(posedge clk) #1;
    `CHK(n_rp, 4)
  endtask
  task automatic t_pipe;
    int k;
    k = 0;
    {n_done, peak} = 0;
    n_wp = 0;
    {req_write, req_line, bad_par, req_valid} = 4'hD;
    // request stays up between takes, so the owner keeps the bus
    for (int i = 0; i < 200 && k < 6; i++) begin
      if (req_ready === 1'b1) k++;
      @(posedge clk) #1;
    end
    req_valid = 1'b0;
    `CHK(k, 6)
    repeat (60) @(posedge clk) #1;
    `CHK(peak, 4'h4)
    `CHK(n_done, 6)
    `CHK(n_wp, 24)
  endtask
  task automatic conclude;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #20000;
    miscompares++;
    conclude;
  end
  initial begin
    {sys_rst, req_valid, req_write, req_line, bad_par, hold_off} = 6'h20;
    {hit, hitm, defer, retry, fail} = 5'h00;
    {req_addr, req_be} = {33'h0_1234_5678, 8'h0F};
    {src_wdata, rd_src} = {64'hA5A5_0F0F_1234_5678, 64'h0123_4567_89AB_CDEF};
    repeat (6) @(posedge clk);
    #1 sys_rst = 1'b0;
    t_read;
    t_write;
    t_error;
    t_codes;
    t_stall;
    t_pipe;
    conclude;
  end
endmodule

// ===== test/txn_bus_chk.sv
// Purpose: bus phase checks between the two ends
// Assumes: one clk, sys_rst synchronous active high
// Notes:   watches the interface wires only
`timescale 1ns/10ps

module txn_bus_chk (
  // clock and reset
  input wire logic           clk,
  input wire logic           sys_rst,
  // bus wires
  input wire logic           address_strobe_n,
  input wire logic           bus_grant,
  input wire logic           error_n,
  input wire logic           snoop_valid,
  input wire logic           resp_valid,
  input wire txn_pkg::resp_t resp_code,
  input wire logic           target_ready_n,
  input wire logic           wdata_valid,
  input wire logic           rdata_valid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ==========================================================
  // phases
  a_strobe_one_clk: assert property (!address_strobe_n |=>
    address_strobe_n) else $error("strobe longer than one clock");
  a_err_three_clk: assert property (!error_n |->
    $past(address_strobe_n, 3) == 1'b0) else $error("error clock off");
  a_snoop_four_clk: assert property (snoop_valid |->
    $past(address_strobe_n, 4) == 1'b0) else $error("snoop too early");
  a_err_no_snoop: assert property (!error_n |=> !snoop_valid)
    else $error("snoop after error");
  a_code_legal: assert property (resp_valid |->
    resp_code inside {[3'h0:3'h5]}) else $error("bad response code");
  a_read_with_resp: assert property (resp_valid &&
    resp_code == txn_pkg::RESP_NORMAL_DATA |-> rdata_valid)
    else $error("read data not with response");
  a_nodata_no_rd: assert property (resp_valid &&
    resp_code == txn_pkg::RESP_NO_DATA |-> !rdata_valid)
    else $error("data on no-data response");
  a_wdata_after_rdy: assert property ($rose(wdata_valid) |->
    $past(target_ready_n) == 1'b0) else $error("write data early");
  a_resp_gap: assert property (resp_valid |=> !resp_valid)
    else $error("responses back to back");
  a_strobe_owner: assert property (!address_strobe_n |->
    $past(bus_grant)) else $error("strobe without grant");
endmodule
